// ---- logic/clk_synth_serial_port.sv ----
// Device end: byte-indexed serial slave holding control bytes 0 and 1
// Notes on behaviour
// R1: Start, address, write bit, slave acknowledges.
// R2: Command byte follows and is acknowledged.
// R3: Command 100xxxxx selects byte, low five index.
// R4: Write data byte acknowledged, stored, then stop.
// R5: Read: repeated start, read address, drive byte.
// R6: Byte0 bit6 sets PCI drive strength, reset one.
// R7: Byte0 bits3,2 mirror live stop pins.
// R8: Byte0 bits1,0 hold power-up frequency selects.
// R9: Byte1 bit7 lets stop requests halt SRC.
// R10: Byte1 bit6 enables SRC pair, else high-Z.
// R11: Byte1 bits2..0 enable CPU pairs, else high-Z.
// R12: Only address 1101001 is answered, write or read.
// R13: Defaults load at power-up without access.
// R14: Status writes ignored; reserved bits fixed.
module clk_synth_serial_port
	import smbus_clk_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// Serial link
	smbus_link_if.device              link,
	// Status pins
	input  wire logic                 pci_stop_pin_n,
	input  wire logic                 cpu_stop_pin_n,
	input  wire logic                 freq_select_first,
	input  wire logic                 freq_select_second,
	input  wire logic                 software_pci_halt,
	// Output control
	output logic                      pci_high_drive,
	output logic                      serial_ref_oe,
	output logic                      serial_ref_halt,
	output logic [CPU_PAIRS-1:0]      cpu_pair_oe
);

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [8:0] {
		S_IDLE      = 9'h001,
		S_ADDR      = 9'h002,
		S_ADDR_ACK  = 9'h004,
		S_CMD       = 9'h008,
		S_CMD_ACK   = 9'h010,
		S_WDATA     = 9'h020,
		S_WDATA_ACK = 9'h040,
		S_RDATA     = 9'h080,
		S_RDATA_ACK = 9'h100
	} dev_state_t;

	typedef struct packed {
		dev_state_t           state;
		logic                 scl_meta;
		logic                 scl_sync;
		logic                 scl_prev;
		logic                 sda_meta;
		logic                 sda_sync;
		logic                 sda_prev;
		logic [3:0]           pin_meta;
		logic [3:0]           pin_sync;
		logic [1:0]           fs_wait;
		logic                 fs_done;
		logic [1:0]           fs_cap;
		logic [7:0]           shift;
		logic [2:0]           cnt;
		logic                 ack_on;
		logic                 rw;
		logic [IDX_W-1:0]     index;
		logic [7:0]           ctrl0;
		logic [7:0]           ctrl1;
		logic                 sda_oe;
		logic                 pci_high_drive;
		logic                 serial_ref_oe;
		logic                 serial_ref_halt;
		logic [CPU_PAIRS-1:0] cpu_pair_oe;
	} dev_regs_t;

	// Defaults match what the control bytes hold after power-up
	// Line samples start at the released level so reset shows no false edge
	localparam dev_regs_t DEV_RESET = '{
		state:          S_IDLE,
		scl_meta:       1'b1,
		scl_sync:       1'b1,
		scl_prev:       1'b1,
		sda_meta:       1'b1,
		sda_sync:       1'b1,
		sda_prev:       1'b1,
		ctrl0:          CTRL0_RESET,
		ctrl1:          CTRL1_RESET,
		pci_high_drive: CTRL0_RESET[BIT_PCI_DRIVE],
		serial_ref_oe:  CTRL1_RESET[BIT_SRC_ENABLE],
		cpu_pair_oe:    CTRL1_RESET[CPU_PAIRS-1:0],
		default:        '0
	};

	dev_regs_t r;
	dev_regs_t next_r;

	// ************************************************************
	// Line events and read data
	// ************************************************************
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic [7:0] rx_byte;
	logic [7:0] live_bits;
	logic [7:0] read_byte;

	assign scl_rise   = r.scl_sync & ~r.scl_prev;
	assign scl_fall   = ~r.scl_sync & r.scl_prev;
	// Data edges while the clock stays high frame a transfer
	assign start_seen = r.scl_sync & r.scl_prev & r.sda_prev & ~r.sda_sync;
	assign stop_seen  = r.scl_sync & r.scl_prev & ~r.sda_prev & r.sda_sync;
	assign rx_byte    = {r.shift[6:0], r.sda_sync};

	// Stop pins are mirrored live, frequency selects as captured
	assign live_bits = {4'h0, r.pin_sync[BIT_PCI_STOP], r.pin_sync[BIT_CPU_STOP],
		r.fs_cap}; // [R7] [R8]

	assign read_byte = (r.index == IDX_CTRL0) ? ((r.ctrl0 & CTRL0_WMASK) | live_bits) :
		(r.index == IDX_CTRL1) ? r.ctrl1 : UNMAPPED_RD;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_r = r;
		next_r.scl_meta = link.scl;
		next_r.scl_sync = r.scl_meta;
		next_r.scl_prev = r.scl_sync;
		next_r.sda_meta = link.sda;
		next_r.sda_sync = r.sda_meta;
		next_r.sda_prev = r.sda_sync;
		next_r.pin_meta = {pci_stop_pin_n, cpu_stop_pin_n, freq_select_second,
			freq_select_first};
		next_r.pin_sync = r.pin_meta;

		// Capture once, after the synchronisers have settled
		if (!r.fs_done) begin
			if (r.fs_wait == FS_SETTLE) begin
				next_r.fs_done = 1'b1;
				next_r.fs_cap  = r.pin_sync[BIT_FS_SECOND:BIT_FS_FIRST]; // [R8]
			end else begin
				next_r.fs_wait = r.fs_wait + 2'h1;
			end
		end

		if (start_seen) begin
			// Also a repeated start: the address phase begins again
			next_r.state  = S_ADDR; // [R1] [R5]
			next_r.cnt    = '0;
			next_r.ack_on = 1'b0;
			next_r.sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_r.state  = S_IDLE;
			next_r.ack_on = 1'b0;
			next_r.sda_oe = 1'b0;
		end else begin
			unique case (r.state)
				S_IDLE: begin
				end
				S_ADDR: begin
					if (scl_rise) begin
						next_r.shift = rx_byte;
						next_r.cnt   = r.cnt + 3'h1;
						if (r.cnt == LAST_BIT) begin
							if (rx_byte[CMD_TOP:ADDR_LSB] == SLAVE_ADDR) begin
								next_r.state = S_ADDR_ACK; // [R1] [R12]
								next_r.rw    = rx_byte[DIR_BIT];
							end else begin
								next_r.state = S_IDLE; // [R12]
							end
						end
					end
				end
				S_CMD: begin
					if (scl_rise) begin
						next_r.shift = rx_byte;
						next_r.cnt   = r.cnt + 3'h1;
						if (r.cnt == LAST_BIT) begin
							// Block transfers are not supported and get no acknowledge
							if (rx_byte[CMD_TOP:CMD_OP_LSB] == BYTE_OP_CODE) begin
								next_r.state = S_CMD_ACK; // [R2] [R3]
								next_r.index = rx_byte[IDX_W-1:0]; // [R3]
							end else begin
								next_r.state = S_IDLE;
							end
						end
					end
				end
				S_WDATA: begin
					if (scl_rise) begin
						next_r.shift = rx_byte;
						next_r.cnt   = r.cnt + 3'h1;
						if (r.cnt == LAST_BIT) begin
							next_r.state = S_WDATA_ACK; // [R4]
							// Only writable bits change; status and reserved stay
							if (r.index == IDX_CTRL0) begin
								next_r.ctrl0 = (r.ctrl0 & ~CTRL0_WMASK) |
									(rx_byte & CTRL0_WMASK); // [R4] [R14]
							end else if (r.index == IDX_CTRL1) begin
								next_r.ctrl1 = (r.ctrl1 & ~CTRL1_WMASK) |
									(rx_byte & CTRL1_WMASK); // [R4] [R14]
							end
						end
					end
				end
				S_ADDR_ACK, S_CMD_ACK, S_WDATA_ACK: begin
					if (scl_fall) begin
						if (!r.ack_on) begin
							next_r.ack_on = 1'b1;
							next_r.sda_oe = 1'b1; // [R1] [R2] [R4] [R5]
						end else begin
							next_r.ack_on = 1'b0;
							next_r.sda_oe = 1'b0;
							next_r.cnt    = '0;
							if (r.state == S_ADDR_ACK && r.rw == DIR_READ) begin
								// First data bit goes out on the same falling edge
								next_r.state  = S_RDATA; // [R5]
								next_r.shift  = read_byte;
								next_r.sda_oe = ~read_byte[CMD_TOP];
							end else if (r.state == S_ADDR_ACK) begin
								next_r.state = S_CMD; // [R2]
							end else if (r.state == S_CMD_ACK) begin
								next_r.state = S_WDATA;
							end else begin
								next_r.state = S_IDLE;
							end
						end
					end
				end
				S_RDATA: begin
					if (scl_fall) begin
						if (r.cnt == LAST_BIT) begin
							next_r.sda_oe = 1'b0;
							next_r.state  = S_RDATA_ACK;
						end else begin
							next_r.shift  = {r.shift[6:0], 1'b0};
							next_r.cnt    = r.cnt + 3'h1;
							next_r.sda_oe = ~r.shift[6]; // [R5]
						end
					end
				end
				S_RDATA_ACK: begin
					// Master acknowledge is not sampled; the ack clock rise returns to idle before the stop
					if (scl_rise) begin
						next_r.state = S_IDLE; // [R5]
					end
				end
			endcase
		end

		// Output controls follow the control bytes one clock later
		next_r.pci_high_drive  = r.ctrl0[BIT_PCI_DRIVE]; // [R6]
		next_r.serial_ref_oe   = r.ctrl1[BIT_SRC_ENABLE]; // [R10]
		next_r.serial_ref_halt = r.ctrl1[BIT_SRC_STOPPABLE] &
			(~r.pin_sync[BIT_PCI_STOP] | software_pci_halt); // [R9]
		next_r.cpu_pair_oe     = r.ctrl1[CPU_PAIRS-1:0]; // [R11]
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			r <= DEV_RESET; // [R13]
		end else begin
			r <= next_r;
		end
	end

	// Open drain: the pin is only ever pulled low
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = r.sda_oe;
	assign pci_high_drive  = r.pci_high_drive;
	assign serial_ref_oe   = r.serial_ref_oe;
	assign serial_ref_halt = r.serial_ref_halt;
	assign cpu_pair_oe     = r.cpu_pair_oe;

endmodule : clk_synth_serial_port

// ---- logic/smbus_byte_master.sv ----
// Host end: master issuing single-byte indexed writes and reads
module smbus_byte_master
	import smbus_clk_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Serial link
	smbus_link_if.host            link,
	// Request
	input  wire logic             req_valid,
	input  wire logic             req_write,
	input  wire logic [IDX_W-1:0] req_index,
	input  wire logic [7:0]       req_wdata,
	// Answer
	output logic                  busy,
	output logic                  done,
	output logic [7:0]            rdata,
	output logic                  nack
);

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_SEND  = 5'h04,
		H_RECV  = 5'h08,
		H_STOP  = 5'h10
	} host_state_t;

	typedef enum logic [2:0] {
		STEP_ADDR_W = 3'h0,
		STEP_CMD    = 3'h1,
		STEP_WDATA  = 3'h2,
		STEP_ADDR_R = 3'h3,
		STEP_DATA_R = 3'h4
	} host_step_t;

	typedef struct packed {
		host_state_t      state;
		host_step_t       step;
		logic             write;
		logic [IDX_W-1:0] index;
		logic [7:0]       wdata;
		logic [7:0]       shift;
		logic [3:0]       bitn;
		logic [1:0]       q;
		logic [3:0]       div;
		logic             ack_bit;
		logic             sda_meta;
		logic             sda_sync;
		logic             scl_oe;
		logic             sda_oe;
		logic             busy;
		logic             done;
		logic [7:0]       rdata;
		logic             nack;
	} host_regs_t;

	// Data samples start at the released level of the line
	localparam host_regs_t HOST_RESET = '{
		state:    H_IDLE,
		step:     STEP_ADDR_W,
		sda_meta: 1'b1,
		sda_sync: 1'b1,
		default:  '0
	};

	host_regs_t r;
	host_regs_t next_r;
	logic       tick;
	logic       scl_hi;
	logic       sda_hi;

	assign tick = (r.div == QUARTER_LAST);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_r = r;
		scl_hi = 1'b1;
		sda_hi = 1'b1;
		next_r.done     = 1'b0;
		next_r.sda_meta = link.sda;
		next_r.sda_sync = r.sda_meta;
		next_r.div      = tick ? 4'h0 : r.div + 4'h1;

		// Each bit is four quarters; the clock is high in the middle two
		unique case (r.state)
			H_IDLE: begin
				next_r.div = 4'h0;
				next_r.q   = 2'h0;
				if (req_valid) begin
					next_r.state = H_START; // [R1]
					next_r.step  = STEP_ADDR_W;
					next_r.write = req_write;
					next_r.index = req_index;
					next_r.wdata = req_wdata;
					next_r.busy  = 1'b1;
					next_r.nack  = 1'b0;
				end
			end
			H_START: begin
				// Clock stands still before the first start; only a repeated start needs it low
				scl_hi = (r.q != 2'h0) || (r.step == STEP_ADDR_W);
				sda_hi = (r.q < 2'h2);
			end
			H_SEND: begin
				scl_hi = (r.q == 2'h1) || (r.q == 2'h2);
				sda_hi = (r.bitn == ACK_SLOT) ? 1'b1 : r.shift[CMD_TOP];
			end
			H_RECV: begin
				scl_hi = (r.q == 2'h1) || (r.q == 2'h2);
				sda_hi = (r.bitn != ACK_SLOT); // [R5]
			end
			H_STOP: begin
				scl_hi = (r.q != 2'h0);
				sda_hi = (r.q >= 2'h2); // [R4] [R5]
			end
		endcase

		if (r.state != H_IDLE && tick) begin
			next_r.q = r.q + 2'h1;
			if (r.q == 2'h2) begin
				if (r.state == H_SEND && r.bitn == ACK_SLOT) begin
					next_r.ack_bit = r.sda_sync;
				end else if (r.state == H_RECV && r.bitn != ACK_SLOT) begin
					next_r.shift = {r.shift[6:0], r.sda_sync};
				end
			end
			if (r.q == 2'h3) begin
				next_r.bitn = 4'h0;
				if (r.state == H_START) begin
					next_r.state = H_SEND;
					next_r.shift = (r.step == STEP_ADDR_R) ? {SLAVE_ADDR, DIR_READ} :
						{SLAVE_ADDR, DIR_WRITE}; // [R12] [R1] [R5]
				end else if (r.state == H_STOP) begin
					next_r.state = H_IDLE;
					next_r.busy  = 1'b0;
					next_r.done  = 1'b1;
				end else if (r.bitn != ACK_SLOT) begin
					next_r.bitn = r.bitn + 4'h1;
					if (r.state == H_SEND) begin
						next_r.shift = {r.shift[6:0], 1'b0};
					end
				end else if (r.state == H_RECV) begin
					next_r.rdata = r.shift;
					next_r.state = H_STOP; // [R5]
				end else if (r.ack_bit) begin
					// No acknowledge: give up the transfer with a stop
					next_r.nack  = 1'b1;
					next_r.state = H_STOP;
				end else begin
					unique case (r.step)
						STEP_ADDR_W: begin
							next_r.step  = STEP_CMD;
							next_r.shift = {BYTE_OP_CODE, r.index}; // [R2] [R3]
						end
						STEP_CMD: begin
							if (r.write) begin
								next_r.step  = STEP_WDATA;
								next_r.shift = r.wdata; // [R4]
							end else begin
								next_r.step  = STEP_ADDR_R;
								next_r.state = H_START; // [R5]
							end
						end
						STEP_WDATA: begin
							next_r.state = H_STOP; // [R4]
						end
						STEP_ADDR_R: begin
							next_r.step  = STEP_DATA_R;
							next_r.state = H_RECV;
						end
						default: begin
							next_r.state = H_STOP;
						end
					endcase
				end
			end
		end

		next_r.scl_oe = ~scl_hi;
		next_r.sda_oe = ~sda_hi;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			r <= HOST_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = r.scl_oe;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = r.sda_oe;
	assign busy             = r.busy;
	assign done             = r.done;
	assign rdata            = r.rdata;
	assign nack             = r.nack;

endmodule : smbus_byte_master

// ---- logic/smbus_clk_pkg.sv ----
// Package: constants shared by the serial control port and its master
package smbus_clk_pkg;

	// ************************************************************
	// Addressing and command decode
	// ************************************************************
	localparam logic [6:0] SLAVE_ADDR   = 7'h69;
	localparam logic       DIR_WRITE    = 1'b0;
	localparam logic       DIR_READ     = 1'b1;
	localparam logic [2:0] BYTE_OP_CODE = 3'h4;
	localparam int         IDX_W        = 5;
	localparam int         CMD_TOP      = 7;
	localparam int         CMD_OP_LSB   = 5;
	localparam int         ADDR_LSB     = 1;
	localparam int         DIR_BIT      = 0;

	// ************************************************************
	// Control bytes
	// ************************************************************
	localparam logic [IDX_W-1:0] IDX_CTRL0   = 5'h00;
	localparam logic [IDX_W-1:0] IDX_CTRL1   = 5'h01;
	localparam logic [7:0]       CTRL0_RESET = 8'h40;
	localparam logic [7:0]       CTRL0_WMASK = 8'h40;
	localparam logic [7:0]       CTRL1_RESET = 8'h7F;
	localparam logic [7:0]       CTRL1_WMASK = 8'hC7;
	localparam logic [7:0]       UNMAPPED_RD = 8'h00;
	localparam int               BIT_PCI_DRIVE     = 6;
	localparam int               BIT_PCI_STOP      = 3;
	localparam int               BIT_CPU_STOP      = 2;
	localparam int               BIT_FS_SECOND     = 1;
	localparam int               BIT_FS_FIRST      = 0;
	localparam int               BIT_SRC_STOPPABLE = 7;
	localparam int               BIT_SRC_ENABLE    = 6;
	localparam int               CPU_PAIRS         = 3;

	// ************************************************************
	// Bit framing and timing
	// ************************************************************
	localparam logic [2:0] LAST_BIT       = 3'h7;
	localparam logic [3:0] ACK_SLOT       = 4'h8;
	localparam logic [1:0] FS_SETTLE      = 2'h3;
	localparam int         SYS_CLK_NS     = 10;
	localparam int         SCL_QUARTER_NS = 80;
	localparam int         QUARTER_CYCLES = (SCL_QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [3:0] QUARTER_LAST   = 4'(QUARTER_CYCLES - 1);

endpackage : smbus_clk_pkg

// ---- logic/smbus_link_if.sv ----
// Interface: open-drain two-wire link between master and clock synthesizer port
interface smbus_link_if;

	// ************************************************************
	// Drivers and resolved wire levels
	// ************************************************************
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up: any enabled low driver wins
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport device (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);

	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);

endinterface : smbus_link_if

// ---- sim/smbus_byte_access_ctrl_regs_sva.sv ----
// Checker: timing and ownership rules watched on the two-wire link
module smbus_byte_access_ctrl_regs_sva (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Link drivers and resolved lines
	input  wire logic host_scl_o,
	input  wire logic host_scl_oe,
	input  wire logic host_sda_o,
	input  wire logic host_sda_oe,
	input  wire logic dev_sda_o,
	input  wire logic dev_sda_oe,
	input  wire logic scl,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Frame tracking
	// ************************************************************
	// Longest frame is a read of 39 bits at 32 cycles, with margin
	localparam int FRAME_MAX = 1400;
	logic        sda_q;
	logic        scl_q;
	logic        in_frame;
	logic [11:0] frame_cycles;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sda_q        <= 1'b1;
			scl_q        <= 1'b1;
			in_frame     <= 1'b0;
			frame_cycles <= 12'h000;
		end else begin
			sda_q        <= sda;
			scl_q        <= scl;
			if (scl && scl_q && sda_q && !sda) begin
				in_frame <= 1'b1;
			end else if (scl && scl_q && !sda_q && sda) begin
				in_frame <= 1'b0;
			end
			frame_cycles <= in_frame ? frame_cycles + 12'h001 : 12'h000;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_SCL_HIGH_TIME: assert property (
		$rose(scl) |-> scl[*8] ##1 scl[*8])
		else $error("clock high phase shorter than two quarters");
	AST_SCL_LOW_TIME: assert property (
		$fell(scl) |-> !scl[*8])
		else $error("clock low phase shorter than a quarter");
	AST_DEV_CHANGE_LOW: assert property (
		$changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("device changed data while clock high");
	AST_START_BY_HOST: assert property (
		scl && $fell(sda) |-> host_sda_oe)
		else $error("start condition not made by the host");
	AST_DEV_IDLE_RELEASED: assert property (
		!in_frame |-> !dev_sda_oe)
		else $error("device pulls data outside a frame");
	AST_OPEN_DRAIN: assert property (
		!host_scl_o && !host_sda_o && !dev_sda_o)
		else $error("driver value not low on open drain line");
	AST_FRAME_BOUND: assert property (
		frame_cycles < FRAME_MAX)
		else $error("frame did not end with a stop in time");
	AST_STOP_HOLD: assert property (
		$fell(in_frame) |-> (scl && sda)[*6])
		else $error("lines not released after stop");

endmodule : smbus_byte_access_ctrl_regs_sva

// ---- sim/tb_smbus_byte_access_ctrl_regs.sv ----
// Testbench: master and serial port joined over the link, driven by requests
`define CHK(nm, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("unexpected %s expected %0h seen %0h", nm, exp, got); \
		end \
	end

module tb_smbus_byte_access_ctrl_regs
	import smbus_clk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Signals
	// ************************************************************
	localparam int LIMIT = 40000;
	logic                 sys_clk;
	logic                 reset;
	logic                 pci_stop_pin_n;
	logic                 cpu_stop_pin_n;
	logic                 freq_select_first;
	logic                 freq_select_second;
	logic                 software_pci_halt;
	logic                 pci_high_drive;
	logic                 serial_ref_oe;
	logic                 serial_ref_halt;
	logic [CPU_PAIRS-1:0] cpu_pair_oe;
	logic                 req_valid;
	logic                 req_write;
	logic [IDX_W-1:0]     req_index;
	logic [7:0]           req_wdata;
	logic                 busy;
	logic                 done;
	logic [7:0]           rdata;
	logic                 nack;
	int                   fail_count;
	int                   comparisons;
	int                   cycles;

	// ************************************************************
	// Design and checker
	// ************************************************************
	smbus_link_if smbus_link_if_i ();

	clk_synth_serial_port clk_synth_serial_port_i (
		.sys_clk(sys_clk), .reset(reset), .link(smbus_link_if_i),
		.pci_stop_pin_n(pci_stop_pin_n), .cpu_stop_pin_n(cpu_stop_pin_n),
		.freq_select_first(freq_select_first), .freq_select_second(freq_select_second),
		.software_pci_halt(software_pci_halt), .pci_high_drive(pci_high_drive),
		.serial_ref_oe(serial_ref_oe), .serial_ref_halt(serial_ref_halt),
		.cpu_pair_oe(cpu_pair_oe));

	smbus_byte_master smbus_byte_master_i (
		.sys_clk(sys_clk), .reset(reset), .link(smbus_link_if_i),
		.req_valid(req_valid), .req_write(req_write), .req_index(req_index),
		.req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata), .nack(nack));

	smbus_byte_access_ctrl_regs_sva smbus_byte_access_ctrl_regs_sva_i (
		.sys_clk(sys_clk), .reset(reset),
		.host_scl_o(smbus_link_if_i.host_scl_o), .host_scl_oe(smbus_link_if_i.host_scl_oe),
		.host_sda_o(smbus_link_if_i.host_sda_o), .host_sda_oe(smbus_link_if_i.host_sda_oe),
		.dev_sda_o(smbus_link_if_i.dev_sda_o), .dev_sda_oe(smbus_link_if_i.dev_sda_oe),
		.scl(smbus_link_if_i.scl), .sda(smbus_link_if_i.sda));

	// ************************************************************
	// Clock, timeout and closing
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			end_sim();
		end
	end

	// ************************************************************
	// Request tasks
	// ************************************************************
	// One request, then wait for done; every slave ack slot must be low
	task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
		int n;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_index <= idx;
		req_wdata <= wd;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		@(negedge sys_clk);
		`CHK("busy", 1'b1, busy)
		n = 0;
		while (n < 2000) begin
			@(negedge sys_clk);
			if (done === 1'b1) break;
			n++;
		end
		if (n == 2000) begin
			fail_count++;
			end_sim();
		end
		`CHK("nack", 1'b0, nack)
		`CHK("busy", 1'b0, busy)
		@(negedge sys_clk);
		`CHK("done", 1'b0, done)
	endtask : xfer

	task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		`CHK("rdata", exp, rdata)
	endtask : rd

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		reset = 1'b1;
		pci_stop_pin_n = 1'b1;
		cpu_stop_pin_n = 1'b0;
		freq_select_first = 1'b1;
		freq_select_second = 1'b0;
		software_pci_halt = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_index = 5'h00;
		req_wdata = 8'h00;
		fail_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		`CHK("pci_high_drive", 1'b1, pci_high_drive)
		`CHK("serial_ref_oe", 1'b1, serial_ref_oe)
		`CHK("serial_ref_halt", 1'b0, serial_ref_halt)
		`CHK("cpu_pair_oe", 3'h7, cpu_pair_oe)
		repeat (10) @(posedge sys_clk);
		// Later pin moves must not reach the captured copy
		freq_select_first <= 1'b0;
		freq_select_second <= 1'b1;
		rd(5'h00, 8'h49);
		rd(5'h01, 8'h7F);
		xfer(1'b1, 5'h01, 8'h00);
		`CHK("serial_ref_oe", 1'b0, serial_ref_oe)
		`CHK("cpu_pair_oe", 3'h0, cpu_pair_oe)
		rd(5'h01, 8'h38);
		xfer(1'b1, 5'h01, 8'h85);
		`CHK("cpu_pair_oe", 3'h5, cpu_pair_oe)
		`CHK("serial_ref_halt", 1'b0, serial_ref_halt)
		rd(5'h01, 8'hBD);
		@(posedge sys_clk);
		software_pci_halt <= 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK("serial_ref_halt", 1'b1, serial_ref_halt)
		@(posedge sys_clk);
		software_pci_halt <= 1'b0;
		pci_stop_pin_n <= 1'b0;
		cpu_stop_pin_n <= 1'b1;
		repeat (6) @(negedge sys_clk);
		`CHK("serial_ref_halt", 1'b1, serial_ref_halt)
		rd(5'h00, 8'h45);
		xfer(1'b1, 5'h00, 8'hBF);
		`CHK("pci_high_drive", 1'b0, pci_high_drive)
		rd(5'h00, 8'h05);
		xfer(1'b1, 5'h00, 8'h40);
		`CHK("pci_high_drive", 1'b1, pci_high_drive)
		xfer(1'b1, 5'h05, 8'hAA);
		rd(5'h05, 8'h00);
		rd(5'h01, 8'hBD);
		end_sim();
	end

endmodule : tb_smbus_byte_access_ctrl_regs
